/* File: inc/ubk_pkg.sv */
// Functional notes
// - Sequential break needs B on later cycle
// - Same-cycle A and B never sequence-match
// - New settings reach comparators after two cycles
// - Paired fetch break survives mid-pair reprogramming
// - Fresh match re-requests when mask below 15
// - Only processor core may access registers
// - Address mask ones exclude address bits
// - Data mask ones exclude data bits
// - Fetch condition requiring write never matches
// - Fetch condition at odd address never matches
// - Peripheral master with fetch never matches
// - Independent mode: either channel raises break
// - Legacy mode: only subset registers effective
// - Legacy mode: no external bus breaks
// - Legacy mode: match flags stay unchanged
// - Legacy fetch break fires even on overrun
// - Native before-exec break skips overrun fetches
// - Legacy mode compares full 32-bit address
// - Native longword access ignores address bits 1:0
// - Native word access ignores address bit 0
package ubk_pkg;

    // Register byte offsets
    localparam logic [7:0] UBK_OFS_A_ADDR = 8'h00;
    localparam logic [7:0] UBK_OFS_A_MASK = 8'h04;
    localparam logic [7:0] UBK_OFS_A_SEL = 8'h08;
    localparam logic [7:0] UBK_OFS_B_ADDR = 8'h0C;
    localparam logic [7:0] UBK_OFS_B_MASK = 8'h10;
    localparam logic [7:0] UBK_OFS_B_SEL = 8'h14;
    localparam logic [7:0] UBK_OFS_B_DATA = 8'h18;
    localparam logic [7:0] UBK_OFS_B_DMASK = 8'h1C;
    localparam logic [7:0] UBK_OFS_CTRL = 8'h20;

    // Control register bit positions
    localparam int UBK_CTL_SEQ = 0;
    localparam int UBK_CTL_A_AFTER = 1;
    localparam int UBK_CTL_B_AFTER = 2;
    localparam int UBK_CTL_EXT = 3;
    localparam int UBK_CTL_LEGACY = 4;
    localparam int UBK_CTL_FLAGS = 8;
    localparam int UBK_CTL_ARMED = 12;

    // Cycle select field positions, two bits each
    localparam int UBK_SEL_MST = 0;
    localparam int UBK_SEL_KIND = 2;
    localparam int UBK_SEL_DIR = 4;
    localparam int UBK_SEL_SIZE = 6;

    // Operand size codes
    localparam logic [1:0] UBK_SZ_NONE = 2'h0;
    localparam logic [1:0] UBK_SZ_BYTE = 2'h1;
    localparam logic [1:0] UBK_SZ_WORD = 2'h2;
    localparam logic [1:0] UBK_SZ_LONG = 2'h3;

    // Shadow stages between register file and comparators
    localparam int UBK_CFG_STAGES = 2;

    // Break settings as software sees them
    typedef struct packed {
        logic [31:0] a_addr;
        logic [31:0] a_mask;
        logic [7:0] a_sel;
        logic [31:0] b_addr;
        logic [31:0] b_mask;
        logic [7:0] b_sel;
        logic [31:0] b_data;
        logic [31:0] b_dmask;
        logic [4:0] ctrl;
    } ubk_cfg_type;

    // One monitored bus cycle
    typedef struct packed {
        logic valid;
        logic is_cpu;
        logic is_ext;
        logic fetch;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] data;
    } ubk_cyc_type;

    // Instruction issue and retire events from the core
    typedef struct packed {
        logic issue;
        logic retire;
        logic [31:0] iss_addr;
    } ubk_exec_type;

    // Whole state of the comparator
    typedef struct packed {
        ubk_cfg_type cfg;
        ubk_cfg_type [UBK_CFG_STAGES-1:0] pipe;
        logic [3:0] flags;
        logic armed;
        logic [3:0] pf_hit;
        logic [29:0] pf_addr;
        logic pf_valid;
        logic [1:0] after_pend;
        logic pend;
        logic req;
        logic ack;
        logic [31:0] dat;
    } ubk_state_type;

    localparam ubk_state_type UBK_STATE_RST = '0;

endpackage

/* File: hdl/ubk_break.sv */
`timescale 1ns/1ps
module ubk_break
    import ubk_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave, tgc high marks the processor core as master
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_tgc_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Monitored bus cycles and core execution, same clock domain
    input wire ubk_cyc_type mon_i,
    input wire ubk_exec_type exe_i,
    input wire logic [3:0] interrupt_mask_level_i,
    // Interrupt controller handshake
    input wire logic brk_ack_i,
    output logic brk_req_o
);

    ubk_state_type q;
    ubk_state_type s;
    ubk_cfg_type act;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Cycle type check; a master, kind or direction group left at 00 can never pass, size 00 passes any size
    function automatic logic sel_ok(input logic [7:0] sl, input ubk_cyc_type c,
                                    input logic legacy, input logic ext_en);
        logic m;
        logic k;
        logic d;
        logic z;
        logic [1:0] sz;
        sz = sl[UBK_SEL_SIZE +: 2];
        if (c.is_cpu) begin
            m = sl[UBK_SEL_MST];
        end else begin
            m = sl[UBK_SEL_MST+1] && (!c.is_ext || (ext_en && !legacy));
        end
        k = c.fetch ? (sl[UBK_SEL_KIND] && c.is_cpu) : sl[UBK_SEL_KIND+1];
        d = c.write ? sl[UBK_SEL_DIR+1] : sl[UBK_SEL_DIR];
        z = (sz == UBK_SZ_NONE) || c.fetch || c.is_ext || (sz == c.size);
        return m && k && d && z;
    endfunction

    // Address compare; mask ones drop bits, native mode drops low bits by size
    function automatic logic adr_ok(input logic [31:0] ba, input logic [31:0] bm,
                                    input logic [31:0] a, input logic [1:0] sz,
                                    input logic legacy);
        logic [31:0] ign;
        ign = bm;
        if (!legacy) begin
            if (sz == UBK_SZ_LONG) begin
                ign = ign | 32'h0000_0003;
            end else if (sz == UBK_SZ_WORD) begin
                ign = ign | 32'h0000_0001;
            end
        end
        return ((ba ^ a) & ~ign) == 32'h0000_0000;
    endfunction

    // Instruction address compare for one half of a fetched pair
    function automatic logic ins_ok(input logic [31:0] ba, input logic [31:0] bm,
                                    input logic [29:0] fa, input logic half);
        logic [31:0] ia;
        ia = {fa, half, 1'b0};
        return !ba[0] && adr_ok(ba, bm, ia, UBK_SZ_BYTE, 1'b1);
    endfunction

    logic wr_sel;
    logic rd_sel;
    logic legacy;
    logic seq;
    logic [1:0] after_sel;
    logic [1:0] sok;
    logic [1:0] dhit;
    logic [1:0] fnow;
    logic [1:0] ihit;
    logic [1:0] rhit;
    logic [1:0] ev;
    logic [3:0] fpair;
    logic bdata_ok;
    logic fire;
    logic [3:0] fset;

    // Comparators always see the oldest shadow copy
    assign act = q.pipe[UBK_CFG_STAGES-1];
    assign legacy = act.ctrl[UBK_CTL_LEGACY];
    assign seq = act.ctrl[UBK_CTL_SEQ];
    // Legacy mode has no after-execution or data registers in effect
    assign after_sel[0] = act.ctrl[UBK_CTL_A_AFTER] && !legacy;
    assign after_sel[1] = act.ctrl[UBK_CTL_B_AFTER] && !legacy;

    // Bus slave decode; non-core masters get an answer but no effect
    assign rd_sel = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr_sel = rd_sel && wb_we_i && wb_tgc_i;

    // Cycle type checks per channel
    assign sok[0] = sel_ok(act.a_sel, mon_i, legacy, act.ctrl[UBK_CTL_EXT]);
    assign sok[1] = sel_ok(act.b_sel, mon_i, legacy, act.ctrl[UBK_CTL_EXT]);

    // Channel B data compare, upper half ignored below longword
    always_comb begin
        logic [31:0] diff;
        diff = (act.b_data ^ mon_i.data) & ~act.b_dmask;
        if (legacy || act.b_sel[UBK_SEL_SIZE +: 2] == UBK_SZ_NONE) begin
            bdata_ok = 1'b1;
        end else if (act.b_sel[UBK_SEL_SIZE +: 2] == UBK_SZ_LONG) begin
            bdata_ok = diff == 32'h0000_0000;
        end else begin
            bdata_ok = diff[15:0] == 16'h0000;
        end
    end

    // Data access hits
    assign dhit[0] = mon_i.valid && !mon_i.fetch && sok[0]
        && adr_ok(act.a_addr, act.a_mask, mon_i.addr, mon_i.size, legacy);
    assign dhit[1] = mon_i.valid && !mon_i.fetch && sok[1] && bdata_ok
        && adr_ok(act.b_addr, act.b_mask, mon_i.addr, mon_i.size, legacy);

    // Fetch hits on both halves of the fetched pair, index = channel*2+half
    assign fpair[0] = ins_ok(act.a_addr, act.a_mask, mon_i.addr[31:2], 1'b0);
    assign fpair[1] = ins_ok(act.a_addr, act.a_mask, mon_i.addr[31:2], 1'b1);
    assign fpair[2] = ins_ok(act.b_addr, act.b_mask, mon_i.addr[31:2], 1'b0);
    assign fpair[3] = ins_ok(act.b_addr, act.b_mask, mon_i.addr[31:2], 1'b1);

    // Legacy breaks on the fetch itself, overrun or not
    assign fnow[0] = legacy && mon_i.valid && mon_i.fetch && sok[0]
        && (fpair[0] || fpair[1]);
    assign fnow[1] = legacy && mon_i.valid && mon_i.fetch && sok[1]
        && (fpair[2] || fpair[3]);

    // Native breaks wait for the core to issue the instruction
    // Legacy mode ignores a pair left latched from native mode
    assign ihit[0] = exe_i.issue && q.pf_valid && q.pf_addr == exe_i.iss_addr[31:2]
        && q.pf_hit[{1'b0, exe_i.iss_addr[1]}] && !legacy;
    assign ihit[1] = exe_i.issue && q.pf_valid && q.pf_addr == exe_i.iss_addr[31:2]
        && q.pf_hit[{1'b1, exe_i.iss_addr[1]}] && !legacy;
    assign rhit = exe_i.retire ? q.after_pend : 2'b00;

    // Channel events; each channel keeps its own before/after choice
    assign ev = dhit | fnow | (ihit & ~after_sel) | rhit;

    // Sequential needs A armed on an earlier cycle
    assign fire = seq ? (ev[1] && q.armed) : (ev[0] || ev[1]);

    // Flag set terms: CPU A, peripheral A, CPU B, peripheral B
    assign fset[0] = !legacy && (ev[0] && (mon_i.is_cpu || !dhit[0]));
    assign fset[1] = !legacy && dhit[0] && !mon_i.is_cpu;
    assign fset[2] = !legacy && (ev[1] && (mon_i.is_cpu || !dhit[1]));
    assign fset[3] = !legacy && dhit[1] && !mon_i.is_cpu;

    // Next-state logic
    always_comb begin
        logic [31:0] w;
        logic [3:0] keep;
        w = wb_dat_i;
        keep = q.flags;
        s = q;
        s.ack = rd_sel;
        // Register writes
        if (wr_sel) begin
            case (wb_adr_i)
                UBK_OFS_A_ADDR: s.cfg.a_addr = merge(q.cfg.a_addr, w, wb_sel_i);
                UBK_OFS_A_MASK: s.cfg.a_mask = merge(q.cfg.a_mask, w, wb_sel_i);
                UBK_OFS_A_SEL: s.cfg.a_sel = wb_sel_i[0] ? w[7:0] : q.cfg.a_sel;
                UBK_OFS_B_ADDR: s.cfg.b_addr = merge(q.cfg.b_addr, w, wb_sel_i);
                UBK_OFS_B_MASK: s.cfg.b_mask = merge(q.cfg.b_mask, w, wb_sel_i);
                UBK_OFS_B_SEL: s.cfg.b_sel = wb_sel_i[0] ? w[7:0] : q.cfg.b_sel;
                UBK_OFS_B_DATA: s.cfg.b_data = merge(q.cfg.b_data, w, wb_sel_i);
                UBK_OFS_B_DMASK: s.cfg.b_dmask = merge(q.cfg.b_dmask, w, wb_sel_i);
                UBK_OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        s.cfg.ctrl = w[4:0];
                    end
                    // Flags clear by writing zero, ones leave them alone
                    if (wb_sel_i[1]) begin
                        keep = q.flags & w[UBK_CTL_FLAGS +: 4];
                    end
                end
                default: s.cfg = q.cfg;
            endcase
        end
        // A new match beats a clear in the same cycle
        s.flags = keep | fset;

        // Shadow copies delay new settings so a fetch in flight is not disturbed
        s.pipe[0] = q.cfg;
        for (int i = 1; i < UBK_CFG_STAGES; i++) begin
            s.pipe[i] = q.pipe[i-1];
        end

        // Latch per-half fetch hits with the settings at fetch time
        if (mon_i.valid && mon_i.fetch && mon_i.is_cpu && !legacy) begin
            s.pf_valid = 1'b1;
            s.pf_addr = mon_i.addr[31:2];
            s.pf_hit = {fpair[3:2] & {2{sok[1]}}, fpair[1:0] & {2{sok[0]}}};
        end

        // After-execution breaks wait for retire
        s.after_pend = (q.after_pend & ~rhit) | (ihit & after_sel);

        // Sequence state
        if (!seq) begin
            s.armed = 1'b0;
        end else if (ev[0]) begin
            s.armed = 1'b1;
        end else if (fire) begin
            s.armed = 1'b0;
        end

        // Request stays pending until accepted; fresh fire wins over acceptance
        s.pend = fire || (q.pend && !brk_ack_i);
        s.req = s.pend && interrupt_mask_level_i != 4'hF;

        // Read data, zero for unmapped addresses and other masters
        s.dat = 32'h0000_0000;
        if (rd_sel && !wb_we_i && wb_tgc_i) begin
            case (wb_adr_i)
                UBK_OFS_A_ADDR: s.dat = q.cfg.a_addr;
                UBK_OFS_A_MASK: s.dat = q.cfg.a_mask;
                UBK_OFS_A_SEL: s.dat = {24'h00_0000, q.cfg.a_sel};
                UBK_OFS_B_ADDR: s.dat = q.cfg.b_addr;
                UBK_OFS_B_MASK: s.dat = q.cfg.b_mask;
                UBK_OFS_B_SEL: s.dat = {24'h00_0000, q.cfg.b_sel};
                UBK_OFS_B_DATA: s.dat = q.cfg.b_data;
                UBK_OFS_B_DMASK: s.dat = q.cfg.b_dmask;
                UBK_OFS_CTRL: begin
                    s.dat[4:0] = q.cfg.ctrl;
                    s.dat[UBK_CTL_FLAGS +: 4] = q.flags;
                    s.dat[UBK_CTL_ARMED] = q.armed;
                end
                default: s.dat = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= UBK_STATE_RST;
        end else begin
            q <= s;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign brk_req_o = q.req;

endmodule

/* File: sim/ubk_core_model.sv */
`timescale 1ns/1ps
module ubk_core_model
    import ubk_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Break request from the comparator
    input wire logic brk_req_i,
    // Bus cycles, core events and break acknowledge
    output ubk_cyc_type mon_o,
    output ubk_exec_type exe_o,
    output logic brk_ack_o
);
    int brk_cnt = 0;
    int hold = 0;
    logic ack_q = 1'b0;
    assign brk_ack_o = ack_q;
    initial begin
        mon_o = '0;
        exe_o = '0;
    end
    // Accept each request once; hold-off covers the request falling late
    always @(posedge clk_i) begin
        ack_q <= 1'b0;
        if (hold > 0) begin
            hold <= hold - 1;
        end else if (brk_req_i) begin
            ack_q <= 1'b1;
            hold <= 4;
            brk_cnt <= brk_cnt + 1;
        end
    end
    // One bus cycle; k is cpu, ext, fetch, write; stale fields are scrambled
    task automatic cyc(input logic [3:0] k, input logic [1:0] sz, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        mon_o <= {1'b1, k, sz, a, d};
        @(posedge clk_i);
        mon_o <= {1'b0, ~k, sz, ~a, ~d};
    endtask
    // One issue or retire pulse from the core
    task automatic ex(input logic iss, input logic ret, input logic [31:0] a);
        @(posedge clk_i);
        exe_o <= {iss, ret, a};
        @(posedge clk_i);
        exe_o <= {2'b00, ~a};
    endtask
endmodule

/* File: sim/ubk_break_props.sv */
`timescale 1ns/1ps
module ubk_break_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_tgc_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Break handshake
    input wire logic [3:0] interrupt_mask_level_i,
    input wire logic brk_ack_i,
    input wire logic brk_req_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> s_ack_pulse)
        else $error("register access not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_FOREIGN_READ: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && !wb_tgc_i |=> wb_dat_o == 32'h0)
        else $error("foreign master read data");
    AST_MASKED_HOLD: assert property (
        !brk_req_o && interrupt_mask_level_i == 4'hF |=> !brk_req_o)
        else $error("break raised at mask level 15");
    AST_REQ_STANDS: assert property (
        brk_req_o && !brk_ack_i && !$past(brk_ack_i) |=> brk_req_o)
        else $error("break request dropped unacknowledged");
    AST_REQ_GATE: assert property (
        $rose(brk_req_o) |-> $past(interrupt_mask_level_i) != 4'hF)
        else $error("break rose under full mask");
endmodule
bind ubk_break ubk_break_props props_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_tgc_i, .wb_dat_o, .wb_ack_o, .interrupt_mask_level_i, .brk_ack_i, .brk_req_o);

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench
    import ubk_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic wb_tgc_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] interrupt_mask_level_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, brk_ack_i, brk_req_o;
    ubk_cyc_type mon_i;
    ubk_exec_type exe_i;
    int fails = 0;
    int compares = 0;
    int base = 0;
    initial forever #2.5 clk_i = ~clk_i;
    ubk_break dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_tgc_i(wb_tgc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon_i(mon_i),
        .exe_i(exe_i), .interrupt_mask_level_i(interrupt_mask_level_i),
        .brk_ack_i(brk_ack_i), .brk_req_o(brk_req_o));
    ubk_core_model core_u (.clk_i(clk_i), .brk_req_i(brk_req_o), .mon_o(mon_i),
        .exe_o(exe_i), .brk_ack_o(brk_ack_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic tgc, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_tgc_i <= tgc;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            n++;
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // The slave answers one cycle after taking the request
        chk(32'(n), 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, 1'b1, a, 32'h0, q);
        chk(q & m, exp);
    endtask
    // All nine registers in offset order, then a dummy read and the settle time
    task automatic setup(input logic [31:0] v [9]);
        logic [31:0] q;
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, 1'b1, 8'(i * 4), v[i], q);
        end
        wb(1'b0, 1'b1, UBK_OFS_CTRL, 32'h0, q);
        repeat (3) @(posedge clk_i);
    endtask
    // Breaks acknowledged since the previous check
    task automatic brk(input int n);
        repeat (10) @(posedge clk_i);
        chk(32'(core_u.brk_cnt - base), 32'(n));
        base = core_u.brk_cnt;
    endtask
    task automatic t_regs();
        logic [31:0] q;
        rd(UBK_OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
        wb(1'b1, 1'b1, UBK_OFS_A_ADDR, 32'h1234_5678, q);
        wb(1'b1, 1'b0, UBK_OFS_A_ADDR, 32'hFFFF_FFFF, q);
        rd(UBK_OFS_A_ADDR, 32'hFFFF_FFFF, 32'h1234_5678);
        wb(1'b0, 1'b0, UBK_OFS_A_ADDR, 32'h0, q);
        chk(q, 32'h0);
        rd(8'h24, 32'hFFFF_FFFF, 32'h0);
    endtask
    task automatic t_masks();
        setup('{32'h0012_3456, 32'hFF, 32'h1E, 32'h0005_5555, 32'h0, 32'h6A, 32'h7878,
                32'h0F0F, 32'h0});
        core_u.cyc(4'b0000, UBK_SZ_BYTE, 32'h0012_34C1, 32'h0);
        brk(1);
        core_u.cyc(4'b0000, UBK_SZ_BYTE, 32'h0012_3556, 32'h0);
        brk(0);
        core_u.cyc(4'b0010, UBK_SZ_NONE, 32'h0012_3454, 32'h0);
        brk(0);
        core_u.cyc(4'b0001, UBK_SZ_BYTE, 32'h0005_5555, 32'h7373);
        brk(1);
        core_u.cyc(4'b0001, UBK_SZ_BYTE, 32'h0005_5555, 32'h6363);
        brk(0);
        // External master cycles break only with the enable set outside legacy mode
        for (int m = 0; m < 2; m++) begin
            setup('{32'h0012_3456, 32'hFF, 32'h1E, 32'h0005_5555, 32'h0, 32'h6A, 32'h7878,
                    32'h0F0F, 32'(8 + m * 16)});
            core_u.cyc(4'b0100, UBK_SZ_BYTE, 32'h0012_34C1, 32'h0);
            brk(m == 0);
        end
    endtask
    task automatic t_size();
        logic [1:0] sz [3] = '{UBK_SZ_LONG, UBK_SZ_WORD, UBK_SZ_BYTE};
        logic [31:0] ad [3] = '{32'h1000, 32'h1002, 32'h1003};
        for (int m = 0; m < 2; m++) begin
            setup('{32'h1003, 32'h0, 32'h19, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'(m * 16)});
            for (int i = 0; i < 3; i++) begin
                core_u.cyc(4'b1000, sz[i], ad[i], 32'h0);
                brk(m == 0 || i == 2);
            end
        end
        // Full mask holds the request back until the level drops
        @(posedge clk_i);
        interrupt_mask_level_i <= 4'hF;
        core_u.cyc(4'b1000, UBK_SZ_BYTE, 32'h1003, 32'h0);
        brk(0);
        interrupt_mask_level_i <= 4'hE;
        brk(1);
    endtask
    task automatic t_seq();
        setup('{32'h100, 32'h0, 32'h19, 32'h100, 32'h100, 32'h19, 32'h0, 32'h0, 32'h1});
        core_u.cyc(4'b1000, UBK_SZ_LONG, 32'h0, 32'h0);
        brk(0);
        core_u.cyc(4'b1000, UBK_SZ_LONG, 32'h100, 32'h0);
        brk(0);
        rd(UBK_OFS_CTRL, 32'h1000, 32'h1000);
        core_u.cyc(4'b1000, UBK_SZ_LONG, 32'h0, 32'h0);
        brk(1);
        rd(UBK_OFS_CTRL, 32'h1000, 32'h0);
    endtask
    task automatic t_fetch();
        setup('{32'h0002_7128, 32'h0, 32'h25, 32'h0003_1415, 32'h0, 32'h15, 32'h0, 32'h0, 32'h0});
        core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h0002_7128, 32'h0);
        core_u.ex(1'b1, 1'b0, 32'h0002_7128);
        core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h0003_1414, 32'h0);
        core_u.ex(1'b1, 1'b0, 32'h0003_1416);
        brk(0);
        for (int m = 0; m < 2; m++) begin
            setup('{32'h404, 32'h0, 32'h15, 32'h8010, 32'h6, 32'h15, 32'h0, 32'h0, 32'(2 + m * 14)});
            core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h8010, 32'h0);
            brk(m);
        end
        rd(UBK_OFS_CTRL, 32'hFFFF_FFFF, 32'h10);
        setup('{32'h404, 32'h0, 32'h15, 32'h8010, 32'h6, 32'h15, 32'h0, 32'h0, 32'h2});
        core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h8014, 32'h0);
        core_u.ex(1'b1, 1'b0, 32'h8016);
        brk(1);
        core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h404, 32'h0);
        core_u.ex(1'b1, 1'b0, 32'h404);
        brk(0);
        core_u.ex(1'b0, 1'b1, 32'h404);
        brk(1);
        rd(UBK_OFS_CTRL, 32'hFFFF_FFFF, 32'h502);
        // Settings change between fetch and issue; the latched pair still breaks
        core_u.cyc(4'b1010, UBK_SZ_NONE, 32'h8014, 32'h0);
        setup('{32'h404, 32'h0, 32'h15, 32'h9000, 32'h6, 32'h15, 32'h0, 32'h0, 32'h2});
        core_u.ex(1'b1, 1'b0, 32'h8016);
        brk(1);
    endtask
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        $display("registers done");
        t_masks();
        $display("masks done");
        t_size();
        $display("sizes done");
        t_seq();
        $display("sequence done");
        t_fetch();
        $display("fetch done");
        end_sim();
    end
    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule
